//--- verilog/rdal_pkg.sv
`default_nettype none
package rdal_pkg;
	// Register byte addresses on the APB window
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_KEY  = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_MAP  = 8'h0c;
	localparam logic [7:0] ADR_THR  = 8'h10;
	localparam logic [7:0] ADR_RID  = 8'h20;
	localparam logic [1:0] NO_IDX   = 2'h3;
	// CTRL fields, then the THR write bit that fills all three positions
	localparam int CB_ACK    = 0;
	localparam int CB_COMMIT = 1;
	localparam int CB_LINE   = 2;
	localparam int CB_EDIT   = 4;
	localparam int CB_HWF    = 5;
	localparam int CB_ERRCLR = 6;
	localparam int TB_ALL    = 24;
	// Timing
	localparam longint CLK_HZ   = 10_000_000;
	localparam longint BEEP_MS  = 200;
	localparam longint GAP_MS   = 200;
	localparam longint BLINK_MS = 500;
	localparam int BEEP_CYC  = int'(BEEP_MS * CLK_HZ / 1000);
	localparam int GAP_CYC   = int'(GAP_MS * CLK_HZ / 1000);
	localparam int BLINK_CYC = int'(BLINK_MS * CLK_HZ / 1000);
	// Characters and stream framing
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_F  = 8'h46;
	localparam logic [7:0] CH_0  = 8'h30;
	localparam logic [7:0] CH_UP = 8'h5e;
	localparam logic [7:0] CH_DN = 8'h76;
	localparam logic [7:0] CH_L  = 8'h4c;
	localparam logic [7:0] CH_C  = 8'h43;
	localparam logic [7:0] CH_R  = 8'h52;
	localparam logic [7:0] CH_BS = 8'h08;
	localparam logic [7:0] STX   = 8'h02;
	localparam logic [7:0] ETX   = 8'h03;
	localparam logic [7:0] EOT   = 8'h04;
	localparam logic [2:0] NFIELD = 3'h7;
	// Field codes
	localparam logic [7:0] POS_NA   = 8'hfe;
	localparam logic [7:0] POS_FAIL = 8'hff;
	localparam logic [7:0] POS_MAX  = 8'h63;
	localparam logic [3:0] LT_NC    = 4'he;
	localparam logic [3:0] LT_FAIL  = 4'hf;
	localparam logic [3:0] LT_MAX   = 4'h5;
	localparam logic [5:0] RWY_MIN  = 6'h01;
	localparam logic [5:0] RWY_MAX  = 6'h24;
	localparam logic [1:0] TR_UP    = 2'h1;
	localparam logic [1:0] TR_DN    = 2'h2;
	localparam logic [1:0] TR_BAD   = 2'h3;
	typedef struct packed {
		logic [1:0] suf;
		logic [5:0] num;
	} rdal_rid_t;
	typedef struct packed {
		rdal_rid_t           rid;
		logic [2:0][7:0]     pos;
		logic [2:0][1:0]     trend;
		logic [3:0]          cl_lt;
		logic [3:0]          edge_lt;
	} rdal_prod_t;
	typedef struct packed {
		rdal_rid_t [2:0]       rid;
		logic [2:0][2:0][7:0]  thr;
		logic [2:0][1:0]       map;
	} rdal_nv_t;
	typedef struct packed {
		logic [19:0][7:0] txt;
		logic [2:0]       blink;
		logic             hl;
	} rdal_line_t;

	// Character formatting shared by every display line
	function automatic logic [3:0][7:0] pos_txt(logic [7:0] v, logic h);
		if (!h || v == POS_NA)
			pos_txt = {4{CH_SP}};
		else if (v == POS_FAIL)
			pos_txt = {CH_SP, CH_F, CH_F, CH_F};
		else
			pos_txt = {CH_0, CH_0, CH_0 + v % 8'h0a,
				CH_0 + v / 8'h0a};
	endfunction

	function automatic logic [7:0] lt_chr(logic [3:0] v, logic h);
		if (!h || v == LT_NC)
			lt_chr = CH_SP;
		else if (v == LT_FAIL)
			lt_chr = CH_F;
		else
			lt_chr = CH_0 + {4'h0, v};
	endfunction

	function automatic logic [7:0] tr_chr(logic [1:0] t, logic h);
		tr_chr = !h ? CH_SP : t == TR_UP ? CH_UP :
			t == TR_DN ? CH_DN : CH_SP;
	endfunction
endpackage
`default_nettype wire

//--- verilog/rdal_rx.sv
`timescale 1ns/1ns
`default_nettype none
module rdal_rx
	import rdal_pkg::*;
(
	input  wire logic  clk_in,
	input  wire logic  rstn_in,
	input  wire logic  rx_valid_in,
	input  wire logic  [7:0] rx_byte_in,
	input  wire logic  rx_perr_in,
	output rdal_prod_t prod_out,
	output logic       prod_valid_out,
	output logic       msg_err_out
);
	typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_BODY = 2'b01,
		RX_BCC = 2'b11, RX_EOT = 2'b10} rdal_rx_st_t;
	rdal_rx_st_t     st_r, st_nxt;
	logic [2:0]      cnt_r, cnt_nxt;
	logic [7:0]      bcc_r, bcc_nxt;
	logic            bad_r, bad_nxt;
	logic [6:0][7:0] buf_r, buf_nxt;
	rdal_prod_t      prod_nxt;
	logic            pv_nxt, err_nxt;

	function automatic logic pos_ok(logic [7:0] v);
		pos_ok = v <= POS_MAX || v == POS_NA || v == POS_FAIL;
	endfunction

	function automatic logic fields_ok(logic [6:0][7:0] b);
		fields_ok = b[0][5:0] >= RWY_MIN && b[0][5:0] <= RWY_MAX
			&& b[0][7:6] == 2'h0 && b[1][7:2] == 6'h00
			&& pos_ok(b[2]) && pos_ok(b[3]) && pos_ok(b[4])
			&& b[5][1:0] != TR_BAD && b[5][3:2] != TR_BAD
			&& b[5][5:4] != TR_BAD
			&& (b[6][3:0] <= LT_MAX || b[6][3:0] == LT_FAIL)
			&& (b[6][7:4] <= LT_MAX || b[6][7:4] >= LT_NC);
	endfunction

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		bcc_nxt = bcc_r;
		bad_nxt = bad_r;
		buf_nxt = buf_r;
		prod_nxt = prod_out;
		pv_nxt = 1'b0;
		err_nxt = 1'b0;
		if (rx_valid_in && rx_perr_in)
		begin
			err_nxt = 1'b1;
			st_nxt = RX_HUNT;
		end
		else if (rx_valid_in)
		begin
			case (st_r)
				RX_HUNT:
				begin
					st_nxt = (rx_byte_in == STX) ? RX_BODY : RX_HUNT;
					err_nxt = rx_byte_in != STX;
					cnt_nxt = 3'h0;
					bcc_nxt = 8'h00;
				end
				RX_BODY:
				begin
					bcc_nxt = bcc_r ^ rx_byte_in;
					if (cnt_r != NFIELD)
					begin
						buf_nxt[cnt_r] = rx_byte_in;
						cnt_nxt = cnt_r + 3'h1;
					end
					else if (rx_byte_in == ETX)
						st_nxt = RX_BCC;
					else
					begin
						err_nxt = 1'b1;
						st_nxt = RX_HUNT;
					end
				end
				RX_BCC:
				begin
					bad_nxt = rx_byte_in != bcc_r;
					st_nxt = RX_EOT;
				end
				RX_EOT:
				begin
					st_nxt = RX_HUNT;
					// Nothing reaches the display unless every check passes
					if (rx_byte_in != EOT || bad_r || !fields_ok(buf_r))
						err_nxt = 1'b1;
					else
					begin
						pv_nxt = 1'b1;
						prod_nxt.rid = {buf_r[1][1:0], buf_r[0][5:0]};
						prod_nxt.pos = {buf_r[4], buf_r[3], buf_r[2]};
						prod_nxt.trend = buf_r[5][5:0];
						prod_nxt.cl_lt = buf_r[6][7:4];
						prod_nxt.edge_lt = buf_r[6][3:0];
					end
				end
				default: st_nxt = RX_HUNT;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			st_r <= RX_HUNT;
			cnt_r <= 3'h0;
			bcc_r <= 8'h00;
			bad_r <= 1'b0;
			buf_r <= '0;
			prod_out <= '0;
			prod_valid_out <= 1'b0;
			msg_err_out <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bcc_r <= bcc_nxt;
			bad_r <= bad_nxt;
			buf_r <= buf_nxt;
			prod_out <= prod_nxt;
			prod_valid_out <= pv_nxt;
			msg_err_out <= err_nxt;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	chk_accept_checked: assert property (prod_valid_out |->
		$past(st_r) == RX_EOT && $past(rx_byte_in) == EOT && !$past(bad_r))
		else $error("product accepted without full check");
	chk_err_exclusive: assert property (msg_err_out |-> !prod_valid_out)
		else $error("message flagged both good and bad");
	cov_accept: cover property (prod_valid_out);
endmodule
`default_nettype wire

//--- verilog/rdal_beep.sv
`timescale 1ns/1ns
`default_nettype none
module rdal_beep
	import rdal_pkg::*;
#(
	parameter int ON_CYC  = BEEP_CYC,
	parameter int OFF_CYC = GAP_CYC
)(
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic three_in,
	input  wire logic one_in,
	input  wire logic cont_in,
	input  wire logic ack_in,
	output logic      beep_out
);
	typedef enum logic [1:0] {BP_IDLE = 2'b00, BP_ON = 2'b01,
		BP_OFF = 2'b11} rdal_bp_st_t;
	rdal_bp_st_t st_r, st_nxt;
	logic [1:0]  rem_r, rem_nxt;
	logic [23:0] tmr_r, tmr_nxt;
	logic        beep_nxt;
	logic [2:0]  n_r;

	always_comb
	begin
		st_nxt = st_r;
		rem_nxt = rem_r;
		tmr_nxt = tmr_r + 24'h1;
		case (st_r)
			BP_ON:
				if (tmr_r == 24'(ON_CYC - 1))
				begin
					tmr_nxt = 24'h0;
					rem_nxt = rem_r - 2'h1;
					st_nxt = (rem_r == 2'h1) ? BP_IDLE : BP_OFF;
				end
			BP_OFF:
				if (tmr_r == 24'(OFF_CYC - 1))
				begin
					tmr_nxt = 24'h0;
					st_nxt = BP_ON;
				end
			default: tmr_nxt = 24'h0;
		endcase
		if (ack_in)
		begin
			st_nxt = BP_IDLE;
			rem_nxt = 2'h0;
		end
		// A new cause in the acknowledge cycle still sounds
		if (three_in || (one_in && st_nxt == BP_IDLE))
		begin
			rem_nxt = three_in ? 2'h3 : 2'h1;
			if (st_nxt == BP_IDLE)
			begin
				st_nxt = BP_ON;
				tmr_nxt = 24'h0;
			end
		end
		// Local fault tone ignores acknowledge
		beep_nxt = cont_in || st_nxt == BP_ON;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			st_r <= BP_IDLE;
			rem_r <= 2'h0;
			tmr_r <= 24'h0;
			beep_out <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			rem_r <= rem_nxt;
			tmr_r <= tmr_nxt;
			beep_out <= beep_nxt;
		end
	end

	// Helper: beep onsets since the last start request
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			n_r <= 3'h0;
		// The onset in the start cycle counts, so a fourth beep shows
		else if (three_in || one_in)
			n_r <= {2'h0, st_nxt == BP_ON && st_r != BP_ON};
		else if (st_nxt == BP_ON && st_r != BP_ON && n_r != 3'h7)
			n_r <= n_r + 3'h1;
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	chk_beep_count: assert property (n_r <= 3'h3)
		else $error("more than three beeps");
	chk_beep_start: assert property (three_in |=> beep_out)
		else $error("alarm start did not beep");
	chk_cont_tone: assert property (cont_in |=> beep_out)
		else $error("fault tone not continuous");
	chk_ack_silence: assert property (
		(ack_in && !three_in && !one_in && !cont_in) |=> !beep_out)
		else $error("beep survived acknowledge");
	cov_three: cover property (three_in ##1 !ack_in [*8]);
endmodule
`default_nettype wire

//--- verilog/rdal_top.sv
`timescale 1ns/1ns
`default_nettype none
module rdal_top
	import rdal_pkg::*;
#(
	parameter int BLINK_N = BLINK_CYC,
	parameter int BEEP_N  = BEEP_CYC,
	parameter int GAP_N   = GAP_CYC
)(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic [7:0] paddr,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr,
	input  wire logic       rx_valid_in,
	input  wire logic [7:0] rx_byte_in,
	input  wire logic       rx_perr_in,
	input  wire rdal_nv_t   nv_image_in,
	input  wire logic       nv_valid_in,
	output rdal_nv_t        nv_image_out,
	output rdal_line_t [2:0] disp_out,
	output logic            beep_out
);
	rdal_prod_t           prod;
	logic                 prod_v;
	rdal_rid_t [2:0]      rid_r, rid_nxt;
	logic [2:0][2:0][7:0] thr_r, thr_nxt;
	logic [2:0][1:0]      map_r, map_nxt;
	logic [2:0][7:0]      ent_r, ent_nxt;
	logic [1:0]           ecnt_r, ecnt_nxt, line_r, line_nxt;
	logic                 edit_r, edit_nxt, hwf_r, hwf_nxt;
	logic                 err_r, err_nxt, load_r;
	logic                 wr, ack_w, bad_w, ok_w;
	logic [1:0]           rec_w;
	logic [7:0]           d0, d1, num_w;
	logic [1:0]           suf_w;
	rdal_prod_t [2:0]     prd_r, prd_nxt;
	logic [2:0]           have_r, have_nxt;
	logic [2:0][2:0]      cond_r, cond_nxt, act_r, act_nxt, rise_w;
	logic [31:0]          rd_nxt;
	rdal_line_t [2:0]     disp_nxt;
	logic [23:0]          bcnt_r, bcnt_nxt;
	logic                 ph_r, ph_nxt;

	function automatic logic [1:0] reg_idx(logic [7:0] a, logic [7:0] b);
		reg_idx = NO_IDX;
		for (int i = 0; i < 3; i++)
			if (a == b + 8'(4 * i))
				reg_idx = 2'(i);
	endfunction

	function automatic logic is_dig(logic [7:0] c);
		is_dig = c >= CH_0 && c <= CH_0 + 8'h09;
	endfunction

	rdal_rx u_rx (
		.clk_in         (clk_in),
		.rstn_in        (rstn_in),
		.rx_valid_in    (rx_valid_in),
		.rx_byte_in     (rx_byte_in),
		.rx_perr_in     (rx_perr_in),
		.prod_out       (prod),
		.prod_valid_out (prod_v),
		.msg_err_out    ()
	);

	rdal_beep #(.ON_CYC(BEEP_N), .OFF_CYC(GAP_N)) u_beep (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.three_in (|rise_w),
		.one_in   (bad_w),
		.cont_in  (hwf_r),
		.ack_in   (ack_w),
		.beep_out (beep_out)
	);

	// APB: zero wait states, unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == ADR_CTRL
		|| paddr == ADR_KEY || paddr == ADR_STAT || paddr == ADR_MAP
		|| reg_idx(paddr, ADR_THR) != NO_IDX
		|| reg_idx(paddr, ADR_RID) != NO_IDX);
	assign wr = psel && penable && pwrite && !pslverr;
	assign nv_image_out = {rid_r, thr_r, map_r};

	// Operator configuration and keyed entry
	always_comb
	begin
		rid_nxt = rid_r;
		thr_nxt = thr_r;
		map_nxt = map_r;
		ent_nxt = ent_r;
		ecnt_nxt = ecnt_r;
		line_nxt = line_r;
		edit_nxt = edit_r;
		hwf_nxt = hwf_r;
		ack_w = 1'b0;
		bad_w = 1'b0;
		d0 = ent_r[0] - CH_0;
		d1 = ent_r[1] - CH_0;
		num_w = 8'(d0 * 8'h0a) + d1;
		suf_w = ent_r[2] == CH_L ? 2'h1 : ent_r[2] == CH_C ? 2'h2 :
			ent_r[2] == CH_R ? 2'h3 : 2'h0;
		ok_w = ecnt_r >= 2'h2 && is_dig(ent_r[0]) && is_dig(ent_r[1])
			&& num_w >= {2'h0, RWY_MIN} && num_w <= {2'h0, RWY_MAX}
			&& (ecnt_r == 2'h2 || ent_r[2] == CH_SP || suf_w != 2'h0);
		rec_w = line_r == NO_IDX ? NO_IDX : map_r[line_r];
		if (load_r)
		begin
			// Restore after power returns; slot only valid after release
			if (nv_valid_in)
				{rid_nxt, thr_nxt, map_nxt} = nv_image_in;
		end
		else if (wr && paddr == ADR_CTRL)
		begin
			ack_w = pwdata[CB_ACK];
			line_nxt = pwdata[CB_LINE+:2];
			edit_nxt = pwdata[CB_EDIT];
			hwf_nxt = pwdata[CB_HWF];
			if (pwdata[CB_COMMIT])
			begin
				bad_w = !ok_w || rec_w == NO_IDX;
				if (!bad_w)
				begin
					rid_nxt[rec_w] = {suf_w, num_w[5:0]};
					if (rid_nxt[rec_w] != rid_r[rec_w])
						thr_nxt[rec_w] = '0;
				end
				ecnt_nxt = 2'h0;
				ent_nxt = {3{CH_SP}};
			end
		end
		else if (wr && paddr == ADR_KEY)
		begin
			if (pwdata[7:0] == CH_BS && ecnt_r != 2'h0)
			begin
				ecnt_nxt = ecnt_r - 2'h1;
				ent_nxt[ecnt_nxt] = CH_SP;
			end
			else if (pwdata[7:0] != CH_BS && ecnt_r != 2'h3)
			begin
				ent_nxt[ecnt_r] = pwdata[7:0];
				ecnt_nxt = ecnt_r + 2'h1;
			end
		end
		else if (wr && paddr == ADR_MAP)
			map_nxt = pwdata[5:0];
		else if (wr && reg_idx(paddr, ADR_THR) != NO_IDX)
			thr_nxt[reg_idx(paddr, ADR_THR)] = pwdata[TB_ALL]
				? {3{pwdata[7:0]}} : pwdata[23:0];
		// A new invalid entry wins over a clear in the same write
		err_nxt = (err_r && !(wr && paddr == ADR_CTRL
			&& pwdata[CB_ERRCLR])) || bad_w;
		rd_nxt = 32'h0;
		if (psel && !penable)
		begin
			if (paddr == ADR_CTRL)
				rd_nxt = {26'h0, hwf_r, edit_r, line_r, 2'h0};
			else if (paddr == ADR_STAT)
				rd_nxt = {27'h0, ecnt_r, |act_r, beep_out, err_r};
			else if (paddr == ADR_MAP)
				rd_nxt = {26'h0, map_r};
			else if (reg_idx(paddr, ADR_THR) != NO_IDX)
				rd_nxt = {8'h0, thr_r[reg_idx(paddr, ADR_THR)]};
			else if (reg_idx(paddr, ADR_RID) != NO_IDX)
				rd_nxt = {23'h0, have_r[reg_idx(paddr, ADR_RID)],
					rid_r[reg_idx(paddr, ADR_RID)]};
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			rid_r <= '0;
			thr_r <= '0;
			map_r <= {NO_IDX, NO_IDX, NO_IDX};
			ent_r <= {3{CH_SP}};
			ecnt_r <= 2'h0;
			line_r <= 2'h0;
			edit_r <= 1'b0;
			hwf_r <= 1'b0;
			err_r <= 1'b0;
			load_r <= 1'b1;
			prdata <= 32'h0;
		end
		else
		begin
			rid_r <= rid_nxt;
			thr_r <= thr_nxt;
			map_r <= map_nxt;
			ent_r <= ent_nxt;
			ecnt_r <= ecnt_nxt;
			line_r <= line_nxt;
			edit_r <= edit_nxt;
			hwf_r <= hwf_nxt;
			err_r <= err_nxt;
			load_r <= 1'b0;
			prdata <= rd_nxt;
		end
	end

	// Products and alarms, kept per runway record
	always_comb
	begin
		prd_nxt = prd_r;
		have_nxt = have_r;
		cond_nxt = cond_r;
		for (int k = 0; k < 3; k++)
		begin
			if (rid_nxt[k] != rid_r[k])
			begin
				have_nxt[k] = 1'b0;
				cond_nxt[k] = 3'h0;
			end
			else if (prod_v && rid_r[k].num != 6'h0
				&& prod.rid == rid_r[k])
			begin
				prd_nxt[k] = prod;
				have_nxt[k] = 1'b1;
				for (int p = 0; p < 3; p++)
					cond_nxt[k][p] = prod.pos[p] == POS_FAIL
						|| (prod.pos[p] <= POS_MAX
						&& prod.pos[p] < thr_r[k][p]);
			end
		end
		// Only a fresh crossing raises; a standing cause stays quiet
		rise_w = cond_nxt & ~cond_r;
		act_nxt = (act_r & {9{!ack_w}} & cond_nxt) | rise_w;
		bcnt_nxt = bcnt_r + 24'h1;
		ph_nxt = ph_r;
		if (bcnt_r == 24'(BLINK_N - 1))
		begin
			bcnt_nxt = 24'h0;
			ph_nxt = !ph_r;
		end
		for (int l = 0; l < 3; l++)
		begin
			automatic logic [1:0] r = map_r[l];
			automatic rdal_prod_t q = prd_r[r[0+:2] == NO_IDX ? 0 : r];
			automatic rdal_rid_t id = r == NO_IDX ? '0 : rid_r[r];
			automatic logic h = r != NO_IDX && have_r[r];
			disp_nxt[l] = '0;
			disp_nxt[l].txt = {20{CH_SP}};
			if (id.num != 6'h0)
			begin
				disp_nxt[l].txt[0] = CH_0 + {2'h0, id.num} / 8'h0a;
				disp_nxt[l].txt[1] = CH_0 + {2'h0, id.num} % 8'h0a;
				disp_nxt[l].txt[2] = id.suf == 2'h1 ? CH_L :
					id.suf == 2'h2 ? CH_C : id.suf == 2'h3 ? CH_R : CH_SP;
				disp_nxt[l].hl = 1'b1;
			end
			if (edit_r && line_r == 2'(l))
			begin
				disp_nxt[l].txt[2:0] = ent_r;
				disp_nxt[l].hl = 1'b1;
			end
			for (int p = 0; p < 3; p++)
			begin
				disp_nxt[l].txt[5 * p + 3 +: 4] = pos_txt(q.pos[p], h);
				disp_nxt[l].txt[5 * p + 7] = tr_chr(q.trend[p], h);
			end
			disp_nxt[l].txt[18] = lt_chr(q.edge_lt, h);
			disp_nxt[l].txt[19] = lt_chr(q.cl_lt, h);
			if (r != NO_IDX)
				disp_nxt[l].blink = act_r[r] & {3{ph_r}};
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			prd_r <= '0;
			have_r <= 3'h0;
			cond_r <= '0;
			act_r <= '0;
			bcnt_r <= 24'h0;
			ph_r <= 1'b0;
			disp_out <= '0;
		end
		else
		begin
			prd_r <= prd_nxt;
			have_r <= have_nxt;
			cond_r <= cond_nxt;
			act_r <= act_nxt;
			bcnt_r <= bcnt_nxt;
			ph_r <= ph_nxt;
			disp_out <= disp_nxt;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	chk_ack_clears: assert property ((ack_w && !(|rise_w)) |=> act_r == '0)
		else $error("acknowledge left an alarm active");
	chk_rearm_alarm: assert property ((|rise_w) |=> (|act_r))
		else $error("new crossing did not raise alarm");
	chk_entry_flag: assert property (bad_w |=> err_r)
		else $error("invalid entry not flagged");
	chk_map_keeps_thr: assert property (
		(wr && paddr == ADR_MAP) |=> $stable(thr_r))
		else $error("thresholds moved with the screen line");
	cov_ack: cover property ((|act_r) ##1 ack_w);
	cov_commit: cover property (wr && paddr == ADR_CTRL
		&& pwdata[CB_COMMIT] && !bad_w);
endmodule
`default_nettype wire

//--- dv/rdal_dpu_m.sv
`timescale 1ns/1ns
`default_nettype none
module rdal_dpu_m
	import rdal_pkg::*;
(
	input  wire logic  clk_in,
	output logic       valid_out,
	output logic [7:0] byte_out,
	output logic       perr_out
);
	initial
	begin
		valid_out = 1'b0;
		byte_out = 8'h00;
		perr_out = 1'b0;
	end
	// Fields low byte first; bad 1 spoils the check code, bad 2 flags parity
	task automatic send(input logic [6:0][7:0] f, input int bad, gap);
		logic [7:0] q[$];
		logic [7:0] x;
		x = ETX;
		q.push_back(STX);
		for (int i = 0; i < 7; i++)
		begin
			q.push_back(f[i]);
			x ^= f[i];
		end
		q.push_back(ETX);
		q.push_back(bad == 1 ? ~x : x);
		q.push_back(EOT);
		foreach (q[i])
		begin
			valid_out <= 1'b1;
			byte_out <= q[i];
			perr_out <= bad == 2 && i == 4;
			@(posedge clk_in);
			// Idle line inverts so a stale byte never reads as fresh
			valid_out <= 1'b0;
			byte_out <= ~q[i];
			perr_out <= 1'b0;
			repeat (gap) @(posedge clk_in);
		end
	endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import rdal_pkg::*;
;
	logic             clk_in, rstn_in, psel, penable, pwrite;
	logic             pready, pslverr, rx_valid, rx_perr, nv_valid, beep, e;
	logic [7:0]       paddr, rx_byte;
	logic [31:0]      pwdata, prdata, d;
	rdal_nv_t         nv, nv_out;
	rdal_line_t [2:0] disp;
	logic [2:0]       bl;
	int               err_count, comparisons, r, h;
	int               cyc = 0;
	rdal_top #(.BLINK_N(8), .BEEP_N(4), .GAP_N(4)) dut (.clk_in(clk_in),
		.rstn_in(rstn_in), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte),
		.rx_perr_in(rx_perr), .nv_image_in(nv), .nv_valid_in(nv_valid),
		.nv_image_out(nv_out), .disp_out(disp), .beep_out(beep));
	rdal_dpu_m dpu (.clk_in(clk_in), .valid_out(rx_valid),
		.byte_out(rx_byte), .perr_out(rx_perr));
	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// Whole run needs a little over a thousand cycles
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [127:0] g, x, input string m);
		comparisons++;
		if (g !== x)
		begin
			err_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, x);
		end
	endtask
	function automatic logic line_ok(input logic [19:0][7:0] t, input string s);
		line_ok = 1'b1;
		for (int i = 0; i < 20; i++)
			if (s[i] != 8'h3f && t[i] !== s[i])
				line_ok = 1'b0;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		@(posedge clk_in);
		while (pready !== 1'b1)
			@(posedge clk_in);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic watch(input int ln, n);
		logic p;
		p = 1'b0;
		r = 0;
		h = 0;
		bl = 3'h0;
		repeat (n)
		begin
			@(posedge clk_in);
			r += int'(beep && !p);
			h += int'(beep);
			bl |= disp[ln].blink;
			p = beep;
		end
	endtask
	task automatic msg(input logic [7:0] td, mp, ro, tr, lt, input int bad, gap);
		dpu.send({lt, tr, ro, mp, td, 8'h03, 8'h0e}, bad, gap);
	endtask
	task automatic low();
		msg(8'h07, 8'h19, 8'h63, 8'h08, 8'h5f, 0, 1);
	endtask
	task automatic clear();
		msg(8'h0c, 8'h19, 8'h63, 8'h00, 8'h53, 0, 1);
		watch(0, 30);
		chk(r, 0, "clear beeps");
	endtask
	task automatic enter(input logic [39:0] ks, input int n);
		apb(1, ADR_CTRL, 32'h14);
		for (int i = 0; i < n; i++)
			apb(1, ADR_KEY, {24'h0, ks[8 * (n - 1 - i) +: 8]});
		apb(1, ADR_CTRL, 32'h16);
	endtask
	task automatic s_reset();
		chk(nv_out, nv, "nv image");
		apb(0, ADR_MAP, 0);
		chk(d, 32'h24, "map restore");
		chk(e, 1'b0, "mapped ok");
		apb(0, ADR_THR, 0);
		chk(d[23:0], 24'h00000a, "thr restore");
		apb(1, ADR_RID, 32'h0);
		apb(0, ADR_RID, 0);
		chk(d[7:0], 8'hce, "rid restore");
		apb(0, 8'h30, 0);
		chk(e, 1'b1, "unmapped err");
	endtask
	task automatic s_stream();
		msg(8'h0c, 8'hfe, 8'hff, 8'h01, 8'he3, 0, 3);
		watch(0, 80);
		chk({r, bl[2]}, {32'd3, 1'b1}, "fail alarm");
		chk(line_ok(disp[0].txt, "14R1200^    ?FFF ?3 "), 1, "line a");
		chk(disp[0].hl, 1'b1, "highlight");
		apb(0, ADR_RID, 0);
		chk(d[8], 1'b1, "product seen");
		apb(1, ADR_CTRL, 32'h1);
		watch(0, 30);
		chk({r, h, bl}, 0, "ack quiet");
		for (int b = 1; b < 4; b++)
		begin
			msg(b == 3 ? 8'h70 : 8'h1e, 8'hfe, 8'hff, 8'h01, 8'he3, b % 3, 1);
			watch(0, 20);
			chk(line_ok(disp[0].txt, "14R1200^    ?FFF ?3 "), 1, "bad msg");
		end
	endtask
	task automatic s_alarm();
		low();
		watch(0, 80);
		chk({r, bl[0]}, {32'd3, 1'b1}, "low alarm");
		chk(line_ok(disp[0].txt, "14R0700 2500v9900 F5"), 1, "line b");
		apb(1, ADR_CTRL, 32'h1);
		clear();
		low();
		watch(0, 6);
		apb(1, ADR_CTRL, 32'h1);
		watch(0, 40);
		chk({r, h, bl}, 0, "ack stop");
		low();
		watch(0, 40);
		chk(r, 0, "no new crossing");
		clear();
		low();
		watch(0, 80);
		chk(r, 3, "rearm");
		apb(1, ADR_CTRL, 32'h20);
		repeat (2) @(posedge clk_in);
		watch(0, 40);
		chk(h, 40, "fault tone");
		apb(1, ADR_CTRL, 32'h21);
		watch(0, 20);
		chk(h, 20, "fault ack");
		apb(1, ADR_CTRL, 32'h0);
		repeat (3) @(posedge clk_in);
		watch(0, 20);
		chk(h, 0, "fault gone");
	endtask
	task automatic s_entry();
		enter({8'h32, 8'h35, CH_BS, 8'h37, CH_L}, 5);
		apb(0, ADR_RID + 8'h04, 0);
		chk(d[7:0], 8'h5b, "entry 27L");
		apb(0, ADR_THR + 8'h04, 0);
		chk(d[23:0], 24'h0, "new rwy thr");
		chk(nv_out.rid[1], {2'h1, 6'h1b}, "nv entry");
		enter({8'h33, 8'h37}, 2);
		watch(0, 30);
		chk(r, 1, "entry beep");
		apb(0, ADR_STAT, 0);
		chk(d[0], 1'b1, "entry error");
		apb(0, ADR_RID + 8'h04, 0);
		chk(d[7:0], 8'h5b, "kept 27L");
		apb(1, ADR_CTRL, 32'h40);
		apb(0, ADR_STAT, 0);
		chk(d[0], 1'b0, "error clear");
		apb(1, ADR_CTRL, 32'h14);
		apb(1, ADR_KEY, 32'h31);
		@(posedge clk_in);
		chk(disp[1].txt[2:0], {CH_SP, CH_SP, 8'h31}, "key shown");
		apb(1, ADR_KEY, {24'h0, CH_BS});
		@(posedge clk_in);
		chk(disp[1].txt[0], CH_SP, "key erased");
		apb(1, ADR_CTRL, 32'h0);
		apb(1, ADR_THR + 8'h08, 32'h0100_0014);
		apb(0, ADR_THR + 8'h08, 0);
		chk(d[23:0], 24'h141414, "whole thr");
		apb(1, ADR_THR + 8'h08, 32'h000a0b0c);
		apb(0, ADR_THR + 8'h08, 0);
		chk(d[23:0], 24'h0a0b0c, "split thr");
	endtask
	task automatic s_move();
		apb(1, ADR_MAP, 32'h09);
		clear();
		low();
		watch(2, 80);
		chk({r, bl[0]}, {32'd3, 1'b1}, "moved alarm");
		chk(line_ok(disp[2].txt, "14R0700?????????????"), 1, "moved");
		chk(disp[0].blink, 3'h0, "line0 calm");
	endtask
	initial
	begin
		rstn_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		nv = '0;
		nv.rid[0] = {2'h3, 6'h0e};
		nv.rid[1] = {2'h0, 6'h09};
		nv.thr[0][0] = 8'h0a;
		nv.thr[1][0] = 8'h05;
		nv.map = {2'h2, 2'h1, 2'h0};
		nv_valid = 1'b1;
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		nv_valid <= 1'b0;
		@(posedge clk_in);
		s_reset();
		s_stream();
		s_alarm();
		s_entry();
		s_move();
		close_out();
	end
endmodule
`default_nettype wire
